//--- dv/agg_assertions.sv
// Port-level assertions for the status event aggregator
`timescale 1ns/10ps
module agg_checker #(
	parameter NUM_REGS = 10
) (
	// Clock, reset, enable
	input wire                   clk_i,
	input wire                   srst_i,
	input wire                   ce_i,
	// Conditions, command and response
	input wire [NUM_REGS*16-1:0] cond_i,
	input wire                   cmd_valid_i,
	input wire [2:0]             cmd_op_i,
	input wire                   cmd_whole_i,
	input wire [3:0]             cmd_index_i,
	input wire                   rsp_valid_o,
	input wire                   rsp_err_o,
	input wire [15:0]            rsp_data_o,
	// Indicators
	input wire [15:0]            summary_o,
	input wire                   service_led_o,
	input wire                   pressure_led_o
);
	wire take      = cmd_valid_i && ce_i;
	wire press_any = |cond_i[9*16+:16];

	default clocking @(posedge clk_i); endclocking
	default disable iff (srst_i);

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_sum_hi;
		summary_o[15:10] == 6'h00;
	endproperty
	a_sum_hi: assert property (p_sum_hi)
		else $error("summary bit above 9 set");
	property p_led_off;
		summary_o == 16'h0000 |-> !service_led_o;
	endproperty
	a_led_off: assert property (p_led_off)
		else $error("service led lit with empty summary");
	// Both edges must be live, else the led legally holds
	property p_press;
		!$past(srst_i) && !$past(srst_i, 2) && $past(ce_i) && $past(ce_i, 2)
			|-> pressure_led_o == $past(press_any, 2);
	endproperty
	a_press: assert property (p_press)
		else $error("pressure led does not follow register 9");
	property p_lat;
		take ##1 ce_i |=> rsp_valid_o;
	endproperty
	a_lat: assert property (p_lat)
		else $error("answer missing two edges after command");
	property p_src;
		rsp_valid_o && $past(ce_i) && $past(ce_i, 2) |-> $past(cmd_valid_i, 2);
	endproperty
	a_src: assert property (p_src)
		else $error("answer without a command");
	property p_bad;
		(take && cmd_op_i < 3'h4 && cmd_index_i > 4'h9) ##1 ce_i
			|=> rsp_err_o && rsp_data_o == 16'h0000;
	endproperty
	a_bad: assert property (p_bad)
		else $error("index above 9 not refused");
	property p_wr;
		(take && (cmd_op_i == 3'h2 || cmd_op_i == 3'h5)) ##1 ce_i
			|=> rsp_data_o == 16'h0000;
	endproperty
	a_wr: assert property (p_wr)
		else $error("write answered with data");
	property p_bit;
		(take && !cmd_whole_i && cmd_op_i != 3'h6) ##1 ce_i
			|=> rsp_data_o[15:1] == 15'h0000;
	endproperty
	a_bit: assert property (p_bit)
		else $error("single bit answer wider than one bit");
endmodule // agg_checker

bind status_event_aggregator agg_checker #(.NUM_REGS(NUM_REGS)) agg_checker_i (
	.clk_i, .srst_i, .ce_i, .cond_i, .cmd_valid_i, .cmd_op_i, .cmd_whole_i,
	.cmd_index_i, .rsp_valid_o, .rsp_err_o, .rsp_data_o, .summary_o,
	.service_led_o, .pressure_led_o);

//--- dv/host_model.sv
// Host model issuing status commands on the command port
`timescale 1ns/10ps
module host_model (
	// Clock and enable
	input  wire         clk_i,
	input  wire         ce_i,
	// Command port
	output logic        cmd_valid_o = 1'b0,
	output logic [2:0]  cmd_op_o = 3'h0,
	output logic        cmd_whole_o = 1'b0,
	output logic [3:0]  cmd_index_o = 4'h0,
	output logic [3:0]  cmd_bit_o = 4'h0,
	output logic [15:0] cmd_data_o = 16'h0000
);
	// Called at a falling edge; k keeps the request up for a follow-on
	task automatic send(input [2:0] op, input w, input [23:0] xbd, input k);
		cmd_valid_o <= 1'b1;
		{cmd_op_o, cmd_whole_o, cmd_index_o, cmd_bit_o} <= {op, w, xbd[23:16]};
		// single writes carry 0 or 1
		cmd_data_o <= (!w && (op == 3'h2 || op == 3'h5)) ?
			{15'h0000, xbd[0]} : xbd[15:0];
		do @(posedge clk_i); while (!ce_i);
		@(negedge clk_i);
		if (!k) begin
			cmd_valid_o <= 1'b0;
			// Idle fields must never look like a held request
			{cmd_op_o, cmd_whole_o, cmd_index_o, cmd_bit_o, cmd_data_o} <=
				~{cmd_op_o, cmd_whole_o, cmd_index_o, cmd_bit_o, cmd_data_o};
			// Let one edge pass so the next request is not raised in this step
			@(negedge clk_i);
		end
	endtask
endmodule // host_model

//--- dv/testbench.sv
// Self-checking bench for the status event aggregator
`timescale 1ns/10ps
`include "status_event_aggregator_consts.vh"
module testbench;
	logic         clk_i = 1'b0;
	logic         srst_i = 1'b1;
	logic         ce_i = 1'b1;
	logic         rnd = 1'b0;
	logic         ce_q = 1'b0;
	logic [159:0] cond_i = '0;
	logic [15:0]  cd[10], ev[10], en[10], sm, s, es;
	logic         el, ep;
	logic [16:0]  q[$];
	int           miscompares = 0;
	int           tests_run = 0;
	wire          cmd_valid_i, cmd_whole_i, rsp_valid_o, rsp_err_o;
	wire          service_led_o, pressure_led_o;
	wire [2:0]    cmd_op_i;
	wire [3:0]    cmd_index_i, cmd_bit_i;
	wire [15:0]   cmd_data_i, rsp_data_o, summary_o;

	always #10 clk_i = ~clk_i;

	status_event_aggregator #(.NUM_REGS(10)) status_event_aggregator_i (
		.clk_i, .srst_i, .ce_i, .cond_i, .cmd_valid_i, .cmd_op_i,
		.cmd_whole_i, .cmd_index_i, .cmd_bit_i, .cmd_data_i, .rsp_valid_o,
		.rsp_err_o, .rsp_data_o, .summary_o, .service_led_o, .pressure_led_o);
	host_model host_model_i (.clk_i, .ce_i, .cmd_valid_o(cmd_valid_i),
		.cmd_op_o(cmd_op_i), .cmd_whole_o(cmd_whole_i),
		.cmd_index_o(cmd_index_i), .cmd_bit_o(cmd_bit_i),
		.cmd_data_o(cmd_data_i));

	// ------------------------------------------------------------
	// Reference model
	// ------------------------------------------------------------
	task automatic run(input [2:0] op, input w, input [3:0] x, b,
		input [15:0] d);
		logic [15:0] r;
		logic        e;
		r = 16'h0000;
		e = op == 3'h7 || (op < 3'h4 && x > 4'h9);
		if (!e) case (op)
			3'h0: r = w ? cd[x] : cd[x][b];
			3'h1: begin
				r = w ? ev[x] : ev[x][b];
				if (w) ev[x] = 16'h0000;
				else ev[x][b] = 1'b0;
			end
			3'h2: if (w) en[x] = d; else en[x][b] = d[0];
			3'h3: r = w ? en[x] : en[x][b];
			3'h4: r = w ? s : s[x];
			3'h5: if (w) sm = d; else sm[x] = d[0];
			default: r = sm;
		endcase
		q.push_back({e, r});
	endtask

	always @(posedge clk_i) begin
		ce_q = ce_i && !srst_i;
		if (srst_i) begin
			cd = '{default: 16'h0000};
			ev = '{default: 16'h0000};
			en = '{1: `SEA_EN1_RST, 5: `SEA_EN5_RST, 6: `SEA_EN6_RST,
				7: `SEA_EN7_RST, 8: `SEA_EN8_RST, default: 16'h0000};
			sm = 16'h01e2;
			{es, el, ep} = '0;
			q.delete();
		end else if (ce_i) begin
			s = 16'h0000;
			foreach (ev[i]) s[i] = |(ev[i] & en[i]);
			es = s;
			el = |(s & sm);
			ep = |cd[9];
			if (cmd_valid_i)
				run(cmd_op_i, cmd_whole_i, cmd_index_i, cmd_bit_i, cmd_data_i);
			// Set wins over a read-clear in the same edge
			foreach (ev[i]) begin
				ev[i] = ev[i] | (cond_i[i*16+:16] & ~cd[i]);
				cd[i] = cond_i[i*16+:16];
			end
		end
	end

	// ------------------------------------------------------------
	// Checking and stimulus helpers
	// ------------------------------------------------------------
	task automatic chk(input [16:0] a, e);
		tests_run++;
		if (a !== e) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, a, e);
		end
	endtask
	task automatic chk_rsp(input [16:0] a);
		chk(a, q.size() ? q.pop_front() : 17'h1ffff);
	endtask
	always @(negedge clk_i) if (!srst_i) begin
		chk(summary_o, es);
		chk(service_led_o, el);
		chk(pressure_led_o, ep);
		if (rsp_valid_o && ce_q) chk_rsp({rsp_err_o, rsp_data_o});
		else if (rsp_valid_o !== 1'b1) chk({rsp_err_o, rsp_data_o}, 17'h00000);
	end
	always @(negedge clk_i) if (rnd) begin
		ce_i <= $urandom % 4 != 0;
		cond_i[$urandom % 160] <= 1'($urandom);
	end
	// Nibbles of v: op, whole, index, bit, then the data word
	task automatic c(input [31:0] v, input k = 1'b0);
		host_model_i.send(v[30:28], v[24], v[23:0], k);
	endtask
	task automatic reset_dut();
		srst_i <= 1'b1;
		repeat (20) @(negedge clk_i);
		srst_i <= 1'b0;
	endtask
	task automatic done(input string t);
		$display("test %s finished, %0d mismatches", t, miscompares);
	endtask
	task automatic results();
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Whole run takes about 900 cycles; this is ample margin
	initial begin
		#400000;
		miscompares++;
		results();
	end

	initial begin
		void'($urandom(24977));
		reset_dut();
		for (int i = 0; i < 10; i++) c({8'h31, i[3:0], 20'h0});
		c(32'h6_1_0_0_0000);
		done("reset_values");
		cond_i[48+:16] <= 16'h8005;
		repeat (2) @(negedge clk_i);
		c(32'h0_1_3_0_0000);
		c(32'h0_0_3_f_0000);
		c(32'h1_0_3_2_0000);
		c(32'h1_0_3_2_0000);
		cond_i[48+:16] <= 16'h0000;
		repeat (2) @(negedge clk_i);
		c(32'h0_1_3_0_0000);
		c(32'h1_1_3_0_0000);
		c(32'h1_1_3_0_0000);
		cond_i[48+:16] <= 16'h0010;
		for (int i = 0; i < 3; i++) c(32'h1_1_3_0_0000);
		done("events");
		cond_i[64+:16] <= 16'h0019;
		c(32'h2_1_4_0_ffff);
		c(32'h2_1_4_0_0019);
		c(32'h2_0_4_3_0000, 1'b1);
		c(32'h3_1_4_0_0000);
		c(32'h3_0_4_3_0000);
		c(32'h3_0_4_4_0000);
		c(32'h4_1_0_0_0000, 1'b1);
		c(32'h4_1_0_0_0000);
		c(32'h4_0_4_0_0000);
		c(32'h4_0_2_0_0000);
		c(32'h5_0_4_0_0001);
		c(32'h6_1_0_0_0000);
		c(32'h5_1_0_0_0002);
		c(32'h1_1_4_0_0000);
		c(32'h2_1_1_0_0000);
		done("summary");
		for (int i = 0; i < 4; i++) c({1'b0, i[2:0], 28'h1a0ffff});
		c(32'h7_1_0_0_0000);
		done("refusals");
		rnd = 1'b1;
		for (int i = 0; i < 400; i++)
			c({1'b0, 3'($urandom), 3'h0, 1'($urandom), 24'($urandom)},
				1'($urandom) && i < 399);
		rnd = 1'b0;
		@(negedge clk_i);
		ce_i <= 1'b1;
		done("random");
		reset_dut();
		c(32'h3_1_8_0_0000);
		c(32'h6_1_0_0_0000);
		done("second_reset");
		repeat (4) @(negedge clk_i);
		chk(17'(q.size()), 17'h00000);
		results();
	end
endmodule // testbench

//--- hdl/enable_mask_bank.v
// Bank of event enable masks with a registered read port
`timescale 1ns/10ps
`include "status_event_aggregator_consts.vh"

module enable_mask_bank #(
	parameter NUM_REGS = `SEA_NUM_REGS
) (
	// Clock, reset, enable
	input  wire                      clk_i,
	input  wire                      srst_i,
	input  wire                      ce_i,
	// Write port
	input  wire                      wr_en_i,
	input  wire                      wr_whole_i,
	input  wire [`SEA_IDX_W-1:0]     wr_idx_i,
	input  wire [3:0]                wr_bit_i,
	input  wire [`SEA_REG_W-1:0]     wr_data_i,
	// Read port
	input  wire                      rd_en_i,
	input  wire [`SEA_IDX_W-1:0]     rd_idx_i,
	output reg  [`SEA_REG_W-1:0]     rd_data_o,
	// All masks side by side for the summary reduction
	output wire [NUM_REGS*16-1:0]    masks_o
);

	reg [`SEA_REG_W-1:0] mem_q [0:NUM_REGS-1];
	integer              i;

	// ----------------------------------------------------------------
	// Power-up assignments
	// ----------------------------------------------------------------
	function [`SEA_REG_W-1:0] rst_val;
		input integer idx;
		begin
			case (idx)
			1:       rst_val = `SEA_EN1_RST;
			5:       rst_val = `SEA_EN5_RST;
			6:       rst_val = `SEA_EN6_RST;
			7:       rst_val = `SEA_EN7_RST;
			8:       rst_val = `SEA_EN8_RST;
			default: rst_val = 16'h0000;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (srst_i) begin
			for (i = 0; i < NUM_REGS; i = i + 1) begin
				mem_q[i] <= rst_val(i);
			end
			rd_data_o <= 16'h0000;
		end else if (ce_i) begin
			if (wr_en_i && wr_idx_i < NUM_REGS) begin
				if (wr_whole_i) begin
					mem_q[wr_idx_i] <= wr_data_i;
				end else begin
					mem_q[wr_idx_i][wr_bit_i] <= wr_data_i[0];
				end
			end
			if (rd_en_i && rd_idx_i < NUM_REGS) begin
				rd_data_o <= mem_q[rd_idx_i];
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < NUM_REGS; g = g + 1) begin : flat
			assign masks_o[g*16 +: 16] = mem_q[g];
		end
	endgenerate

endmodule // enable_mask_bank

//--- hdl/status_event_aggregator.v
// Status condition, event latch, summary and LED logic with command port
`timescale 1ns/10ps
`include "status_event_aggregator_consts.vh"

module status_event_aggregator #(
	parameter NUM_REGS = `SEA_NUM_REGS
) (
	// Clock, reset, enable
	input  wire                      clk_i,
	input  wire                      srst_i,
	input  wire                      ce_i,
	// Monitored parameters, 1 = abnormal, register n in bits n*16+15..n*16
	input  wire [NUM_REGS*16-1:0]    cond_i,
	// Command port
	input  wire                      cmd_valid_i,
	input  wire [`SEA_OP_W-1:0]      cmd_op_i,
	input  wire                      cmd_whole_i,
	input  wire [`SEA_IDX_W-1:0]     cmd_index_i,
	input  wire [3:0]                cmd_bit_i,
	input  wire [`SEA_REG_W-1:0]     cmd_data_i,
	// Response port
	output reg                       rsp_valid_o,
	output reg                       rsp_err_o,
	output reg  [`SEA_REG_W-1:0]     rsp_data_o,
	// Indicators
	output reg  [`SEA_REG_W-1:0]     summary_o,
	output reg                       service_led_o,
	output reg                       pressure_led_o
);

	localparam VW = NUM_REGS * 16;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function [15:0] pick16;
		input [VW-1:0]           vec;
		input [`SEA_IDX_W-1:0]   idx;
		integer                  k;
		begin
			pick16 = 16'h0000;
			for (k = 0; k < NUM_REGS; k = k + 1) begin
				if (idx == k) begin
					pick16 = vec[k*16 +: 16];
				end
			end
		end
	endfunction

	function [VW-1:0] bit_mask;
		input [`SEA_IDX_W-1:0]   idx;
		input                    whole;
		input [3:0]              bitpos;
		integer                  k;
		begin
			bit_mask = {VW{1'b0}};
			for (k = 0; k < NUM_REGS; k = k + 1) begin
				if (idx == k) begin
					if (whole) begin
						bit_mask[k*16 +: 16] = 16'hffff;
					end else begin
						bit_mask[k*16 + bitpos] = 1'b1;
					end
				end
			end
		end
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	reg  [VW-1:0]           cond_q;
	reg  [VW-1:0]           event_q;
	reg  [VW-1:0]           event_d;
	reg  [`SEA_REG_W-1:0]   smask_q;
	reg  [`SEA_REG_W-1:0]   summary_d;

	// Stage between command acceptance and answer
	reg                     p_valid_q;
	reg                     p_err_q;
	reg                     p_whole_q;
	reg                     p_from_mask_q;
	reg  [3:0]              p_bit_q;
	reg  [`SEA_REG_W-1:0]   p_word_q;

	wire [VW-1:0]           masks;
	wire [`SEA_REG_W-1:0]   mask_rd;

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	wire take     = cmd_valid_i;
	wire idx_ok   = (cmd_index_i < NUM_REGS);
	wire is_cond  = (cmd_op_i == `SEA_OP_COND_Q);
	wire is_event = (cmd_op_i == `SEA_OP_EVENT_Q);
	wire is_enw   = (cmd_op_i == `SEA_OP_ENABLE_W);
	wire is_enq   = (cmd_op_i == `SEA_OP_ENABLE_Q);
	wire is_glob  = (cmd_op_i == `SEA_OP_GLOBAL_Q);
	wire is_smw   = (cmd_op_i == `SEA_OP_SMASK_W);
	wire is_smq   = (cmd_op_i == `SEA_OP_SMASK_Q);
	wire needs_ix = is_cond | is_event | is_enw | is_enq;
	wire known    = needs_ix | is_glob | is_smw | is_smq;
	wire cmd_err  = ~known | (needs_ix & ~idx_ok);
	wire ev_read  = take & is_event & idx_ok;
	wire [VW-1:0] ev_clr = ev_read ?
		bit_mask(cmd_index_i, cmd_whole_i, cmd_bit_i) : {VW{1'b0}};

	// Rising edges of the monitored inputs
	wire [VW-1:0] rise = cond_i & ~cond_q;

	// ----------------------------------------------------------------
	// Event latch and summary
	// ----------------------------------------------------------------
	integer n;
	always @* begin
		// Set after clear, so a coinciding edge survives
		event_d = (event_q & ~ev_clr) | rise;
		summary_d = 16'h0000;
		for (n = 0; n < NUM_REGS; n = n + 1) begin
			summary_d[n] = |(event_q[n*16 +: 16] & masks[n*16 +: 16]);
		end
	end

	always @(posedge clk_i) begin
		if (srst_i) begin
			cond_q  <= {VW{1'b0}};
			event_q <= {VW{1'b0}};
		end else if (ce_i) begin
			cond_q  <= cond_i;
			// Latch on rise, clear on read
			event_q <= event_d;
		end
	end

	// ----------------------------------------------------------------
	// Service mask
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (srst_i) begin
			smask_q <= `SEA_SMASK_RST;
		end else if (ce_i && take && is_smw) begin
			if (cmd_whole_i) begin
				smask_q <= cmd_data_i;
			end else begin
				smask_q[cmd_index_i] <= cmd_data_i[0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Enable masks
	// ----------------------------------------------------------------
	enable_mask_bank #(
		.NUM_REGS (NUM_REGS)
	) u_masks (
		.clk_i      (clk_i),
		.srst_i     (srst_i),
		.ce_i       (ce_i),
		.wr_en_i    (take & is_enw & idx_ok),
		.wr_whole_i (cmd_whole_i),
		.wr_idx_i   (cmd_index_i),
		.wr_bit_i   (cmd_bit_i),
		.wr_data_i  (cmd_data_i),
		.rd_en_i    (take & is_enq),
		.rd_idx_i   (cmd_index_i),
		.rd_data_o  (mask_rd),
		.masks_o    (masks)
	);

	// ----------------------------------------------------------------
	// Capture stage
	// ----------------------------------------------------------------
	// Word is sampled at acceptance so a read-clear answers the old value
	always @(posedge clk_i) begin
		if (srst_i) begin
			p_valid_q     <= 1'b0;
			p_err_q       <= 1'b0;
			p_whole_q     <= 1'b0;
			p_from_mask_q <= 1'b0;
			p_bit_q       <= 4'h0;
			p_word_q      <= 16'h0000;
		end else if (ce_i) begin
			p_valid_q     <= take;
			p_err_q       <= take & cmd_err;
			p_whole_q     <= cmd_whole_i | is_enw | is_smw | is_smq;
			p_from_mask_q <= is_enq;
			p_bit_q       <= is_glob ? cmd_index_i : cmd_bit_i;
			p_word_q      <= 16'h0000;
			if (take && !cmd_err) begin
				case (cmd_op_i)
				`SEA_OP_COND_Q: begin
					p_word_q <= pick16(cond_q, cmd_index_i);
				end
				`SEA_OP_EVENT_Q: begin
					p_word_q <= pick16(event_q, cmd_index_i);
				end
				`SEA_OP_GLOBAL_Q: begin
					p_word_q <= summary_d;
				end
				`SEA_OP_SMASK_Q: begin
					p_word_q <= smask_q;
				end
				default: begin
					p_word_q <= 16'h0000;
				end
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// Answer stage
	// ----------------------------------------------------------------
	wire [15:0] ans_word = p_from_mask_q ? mask_rd : p_word_q;

	always @(posedge clk_i) begin
		if (srst_i) begin
			rsp_valid_o <= 1'b0;
			rsp_err_o   <= 1'b0;
			rsp_data_o  <= 16'h0000;
		end else if (ce_i) begin
			rsp_valid_o <= p_valid_q;
			rsp_err_o   <= p_err_q;
			if (!p_valid_q || p_err_q) begin
				rsp_data_o <= 16'h0000;
			end else if (p_whole_q) begin
				rsp_data_o <= ans_word;
			end else begin
				rsp_data_o <= {15'h0000, ans_word[p_bit_q]};
			end
		end
	end

	// ----------------------------------------------------------------
	// Indicators
	// ----------------------------------------------------------------
	always @(posedge clk_i) begin
		if (srst_i) begin
			summary_o      <= 16'h0000;
			service_led_o  <= 1'b0;
			pressure_led_o <= 1'b0;
		end else if (ce_i) begin
			summary_o      <= summary_d;
			service_led_o  <= |(summary_d & smask_q);
			pressure_led_o <= |pick16(cond_q, `SEA_PRESSURE_IDX);
		end
	end

endmodule // status_event_aggregator

//--- hdl/status_event_aggregator_consts.vh
// Constants for the status event aggregator: codes, reset values, layout
//
// Contract
// - Summary bit set when its event register has any enabled set bit
// - Summary bit is zero whenever that register's enable mask is empty
// - Reading the summary changes neither the summary nor any event
// - 16-bit service mask; service LED lit when summary and mask overlap
// - Pressure LED follows condition register 9 directly, not configurable
// - Whole condition query returns the full selected condition register
// - Condition query with bit position returns that single bit
// - Whole event read returns register then clears all its bits
// - Single event bit read returns that bit then clears only it
// - Whole enable write replaces the mask; unlisted bits become zero
// - Single enable write gives index, bit, value; only that bit changes
// - Whole enable query returns the full selected enable mask
// - Single enable query answers 0 for disabled, 1 for enabled
// - Summary is read-only; whole query returns all summary bits
// - Summary query for one index answers 1 if enabled event set
// - Whole service mask write replaces mask; other bits disabled
// - Single service mask write changes only the indexed bit
// - Event bit sets on condition rising edge, latched until read
// - Condition bit is 1 while abnormal, 0 once normal again
// - Ten register sets, indices 0..9, 16 bits; summary bit n is index n
// - Service mask powers up to 482 (bits 1, 5, 6, 7, 8)
`ifndef STATUS_EVENT_AGGREGATOR_CONSTS_VH
`define STATUS_EVENT_AGGREGATOR_CONSTS_VH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define SEA_NUM_REGS      10
`define SEA_REG_W         16
`define SEA_IDX_W         4
`define SEA_PRESSURE_IDX  4'h9

// ----------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------
`define SEA_OP_W          3
`define SEA_OP_COND_Q     3'h0
`define SEA_OP_EVENT_Q    3'h1
`define SEA_OP_ENABLE_W   3'h2
`define SEA_OP_ENABLE_Q   3'h3
`define SEA_OP_GLOBAL_Q   3'h4
`define SEA_OP_SMASK_W    3'h5
`define SEA_OP_SMASK_Q    3'h6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SEA_SMASK_RST     16'h01e2
`define SEA_EN1_RST       16'hc580
`define SEA_EN5_RST       16'h0001
`define SEA_EN6_RST       16'h00e0
`define SEA_EN7_RST       16'h000f
`define SEA_EN8_RST       16'h00ef

`endif
